// ### rtl/dacil_top.sv
`timescale 1ns/1ns
`include "dacil_defs.svh"
// ----------------------------------------------------------------------------
// Digital front end of a current-output converter.
// ----------------------------------------------------------------------------
// Operation
// - A sample word is captured on every rising edge of the sample clock.
// - The highest-numbered data input is the most significant bit.
// - The lowest-numbered data input is the least significant bit.
// - Format select low means straight binary, high means twos complement.
// - Power-down input high powers down; its pull-down means an open pin is normal.
// - In straight binary, all ones drive full scale on the primary output.
// - In straight binary, all zeros drive full scale on the complementary output.
// - In straight binary, all zeros give zero primary current; all ones give zero complementary current.
// - Primary current scales linearly with the unsigned code 0 to 1023.
module dacil_top
    import dacil_pkg::*;
#(
    parameter int DEPTH = `DACIL_FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // Sample pins, asynchronous to mclk.
    input  wire logic [9:0]    sample_pins,
    input  wire logic          format_select,
    input  wire logic          power_down_req,
    // Capture stream handshake toward the analog core.
    output logic               capture_ready,
    input  wire logic          core_ready,
    // Current drive levels.
    output dacil_pkg::dacil_drive_t drive,
    output logic               drive_valid
);
    import dacil_pkg::*;

    dacil_code_t  pin_s1_reg;
    dacil_code_t  pin_s2_reg;
    logic         fmt_s1_reg;
    logic         fmt_s2_reg;
    logic         pd_s1_reg;
    logic         pd_s2_reg;
    dacil_code_t  code_next;
    dacil_code_t  fifo_code;
    logic         fifo_valid;
    logic         fifo_pop;
    dacil_state_t state_reg;
    dacil_drive_t drive_reg;
    logic         valid_reg;

    // ------------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------------
    // Pins pass two flops; the first flop feeds only the second.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1_reg <= `DACIL_CODE_ZERO;
            pin_s2_reg <= `DACIL_CODE_ZERO;
            fmt_s1_reg <= `DACIL_FMT_BINARY;
            fmt_s2_reg <= `DACIL_FMT_BINARY;
            pd_s1_reg  <= 1'b0;
            pd_s2_reg  <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= sample_pins;
            pin_s2_reg <= pin_s1_reg;
            fmt_s1_reg <= format_select;
            fmt_s2_reg <= fmt_s1_reg;
            pd_s1_reg  <= power_down_req; // Reset low stands in for the pull-down.
            pd_s2_reg  <= pd_s1_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Format conversion.
    // ------------------------------------------------------------------------
    // Bit 9 is the top bit and bit 0 the bottom bit of the code.
    always_comb
    begin
        code_next = pin_s2_reg;
        if (fmt_s2_reg == `DACIL_FMT_TWOS)
            code_next[`DACIL_CODE_MSB] = ~pin_s2_reg[`DACIL_CODE_MSB];
    end

    // ------------------------------------------------------------------------
    // Sample buffer.
    // ------------------------------------------------------------------------
    // One word is offered every edge; a stalled core shows as capture_ready low.
    // Capture and drain run at the same rate, so after a stall the buffer stays
    // nearly full and adds its depth in latency until reset, as sleep stops both sides.
    dacil_fifo #(
        .WIDTH (`DACIL_CODE_W),
        .DEPTH (DEPTH)
    ) dacil_fifo_i (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_data   (code_next),
        .in_valid  (state_reg == DACIL_RUN),
        .in_ready  (capture_ready),
        .out_data  (fifo_code),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // The drive register takes a word whenever the core accepts one.
    assign fifo_pop = fifo_valid && core_ready && (state_reg == DACIL_RUN);

    // ------------------------------------------------------------------------
    // Operating state.
    // ------------------------------------------------------------------------
    // Sleep stops capture and drain; buffered samples are held over a power-down.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= DACIL_IDLE;
        else
        begin
            case (state_reg)
                DACIL_IDLE:  state_reg <= pd_s2_reg ? DACIL_SLEEP : DACIL_RUN;
                DACIL_RUN:   state_reg <= pd_s2_reg ? DACIL_SLEEP : DACIL_RUN;
                DACIL_SLEEP: state_reg <= pd_s2_reg ? DACIL_SLEEP : DACIL_RUN;
                default:     state_reg <= DACIL_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Output drive.
    // ------------------------------------------------------------------------
    // Primary carries the code and complementary its inverse, 1023 minus code,
    // so all ones and all zeros land at the two full-scale endpoints.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_reg <= '{primary: `DACIL_CODE_ZERO, complementary: `DACIL_CODE_ZERO,
                           powered_down: 1'b1};
            valid_reg <= 1'b0;
        end
        else if (state_reg != DACIL_RUN)
        begin
            drive_reg <= '{primary: `DACIL_CODE_ZERO, complementary: `DACIL_CODE_ZERO,
                           powered_down: 1'b1};
            valid_reg <= 1'b0;
        end
        else if (fifo_pop)
        begin
            drive_reg.primary       <= fifo_code;
            drive_reg.complementary <= `DACIL_CODE_FULL ^ fifo_code;
            drive_reg.powered_down  <= 1'b0;
            valid_reg               <= 1'b1;
        end
    end

    // Outputs come straight from the drive flops, so they never glitch.
    assign drive       = drive_reg;
    assign drive_valid = valid_reg;

    // ------------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------------
    // The checks watch the path from the synced pins to the drive flops.
    // The analog currents themselves are outside this block, so the codes
    // on the drive struct stand in for them.
    a_drive_complement: assert property (@(posedge mclk) disable iff (!rst_b)
        !drive.powered_down |-> (drive.primary ^ drive.complementary) == 10'h3ff)
        else $error("Outputs are not complementary.");
    a_full_primary: assert property (@(posedge mclk) disable iff (!rst_b)
        fifo_pop && fifo_code == 10'h3ff |=> drive.primary == 10'h3ff
        && drive.complementary == 10'h000)
        else $error("All ones did not give full primary.");
    a_zero_primary: assert property (@(posedge mclk) disable iff (!rst_b)
        fifo_pop && fifo_code == 10'h000 |=> drive.primary == 10'h000
        && drive.complementary == 10'h3ff)
        else $error("All zeros did not give zero primary.");
    // Sleep entry takes two steps: the state first, then the drive flops.
    sequence s_sleep_req;
        pd_s2_reg;
    endsequence
    sequence s_sleep_state;
        state_reg == DACIL_SLEEP;
    endsequence
    sequence s_outputs_off;
        drive.powered_down && !drive_valid;
    endsequence
    a_pd_enter: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sleep_req |=> s_sleep_state ##1 s_outputs_off)
        else $error("Power-down request not honoured.");
    sequence s_sample_in;
        state_reg == DACIL_RUN && capture_ready && !fifo_valid;
    endsequence
    a_capture_path: assert property (@(posedge mclk) disable iff (!rst_b)
        s_sample_in |=> fifo_valid && fifo_code == $past(code_next))
        else $error("Captured word lost.");
    a_twos_msb: assert property (@(posedge mclk) disable iff (!rst_b)
        fmt_s2_reg |-> code_next[9] != pin_s2_reg[9])
        else $error("Top bit not inverted in twos complement.");
    a_binary_pass: assert property (@(posedge mclk) disable iff (!rst_b)
        !fmt_s2_reg |-> code_next == pin_s2_reg)
        else $error("Binary word altered.");
    a_bit_order: assert property (@(posedge mclk) disable iff (!rst_b)
        code_next[8:0] == pin_s2_reg[8:0])
        else $error("Lower bits reordered.");
    a_linear_code: assert property (@(posedge mclk) disable iff (!rst_b)
        fifo_pop |=> drive.primary == $past(fifo_code) && drive_valid)
        else $error("Primary does not follow the code.");
    a_valid_hold: assert property (@(posedge mclk) disable iff (!rst_b)
        drive_valid && state_reg == DACIL_RUN |=> drive_valid)
        else $error("Drive valid dropped while running.");
    // Sleep and wake.
    a_wake_run: assert property (@(posedge mclk) disable iff (!rst_b)
        !pd_s2_reg && state_reg != DACIL_RUN |=> state_reg == DACIL_RUN)
        else $error("Released power-down did not return to run.");
    // Buffer refusal and retention.
    a_full_refuse: assert property (@(posedge mclk) disable iff (!rst_b)
        !capture_ready && !fifo_pop |=> !capture_ready)
        else $error("Full buffer took a word.");
    a_sleep_keep: assert property (@(posedge mclk) disable iff (!rst_b)
        state_reg == DACIL_SLEEP && fifo_valid |=> fifo_valid)
        else $error("Buffered words lost in sleep.");
endmodule : dacil_top

// ### rtl/dacil_defs.svh
`ifndef DACIL_DEFS_SVH
`define DACIL_DEFS_SVH
// ----------------------------------------------------------------------------
// Constants of the converter input latch.
// ----------------------------------------------------------------------------
`define DACIL_CODE_W      10
`define DACIL_CODE_MSB    9
`define DACIL_CODE_FULL   10'h3ff
`define DACIL_CODE_ZERO   10'h000
`define DACIL_FIFO_DEPTH  16
`define DACIL_FMT_BINARY  1'b0
`define DACIL_FMT_TWOS    1'b1
`endif

// ### rtl/dacil_pkg.sv
`include "dacil_defs.svh"
// ----------------------------------------------------------------------------
// Types of the converter input latch.
// ----------------------------------------------------------------------------
package dacil_pkg;
    typedef logic [`DACIL_CODE_W-1:0] dacil_code_t;

    // Drive levels for the two current outputs, as codes of full scale.
    typedef struct packed {
        dacil_code_t primary;
        dacil_code_t complementary;
        logic        powered_down;
    } dacil_drive_t;

    typedef enum logic [1:0] {DACIL_IDLE, DACIL_RUN, DACIL_SLEEP} dacil_state_t;
endpackage : dacil_pkg

// ### rtl/dacil_fifo.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------------------
module dacil_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_b,
    // Fill side.
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side.
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_reg];

    // Storage is written without reset; the count guards stale words.
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_reg[wr_reg] <= in_data;
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
            cnt_reg <= (AW+1)'(cnt_reg + push - pop);
        end
    end
endmodule : dacil_fifo

// ### tb/dacil_source.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Digital sample source that feeds the converter pins.
// ----------------------------------------------------------------------------
module dacil_source (
    // Clock.
    input  wire logic       mclk,
    // Word to present next.
    input  wire logic [9:0] word_in,
    // Pins toward the converter.
    output logic [9:0]      sample_pins
);
    // Start from a defined word so the pins are never unknown.
    initial sample_pins = 10'h000;

    // Change on the falling edge, so the word is steady around every rising edge.
    always @(negedge mclk)
    begin
        sample_pins <= word_in;
    end
endmodule : dacil_source

// ### tb/dac_input_latch_format_bench.sv
`timescale 1ns/1ns
`include "dacil_defs.svh"
// ----------------------------------------------------------------------------
// Self-checking bench of the converter input latch.
// ----------------------------------------------------------------------------
module dac_input_latch_format_bench;
    import dacil_pkg::*;
    logic         mclk = 1'b0;
    logic         rst_b = 1'b0;
    logic [9:0]   word_in = 10'h000;
    logic [9:0]   sample_pins;
    logic         format_select = 1'b0;
    logic         power_down_req = 1'b0;
    logic         core_ready = 1'b1;
    logic         capture_ready;
    dacil_drive_t drive;
    logic         drive_valid;
    int           bad_count = 0;
    int           n_compared = 0;
    dacil_code_t  w;
    dacil_code_t  hist [$];

    // Clock at 25 MHz.
    always #20 mclk = ~mclk;

    dacil_source dacil_source_i (.mclk(mclk), .word_in(word_in), .sample_pins(sample_pins));

    dacil_top #(.DEPTH(`DACIL_FIFO_DEPTH)) dacil_top_i (
        .mclk(mclk), .rst_b(rst_b), .sample_pins(sample_pins),
        .format_select(format_select), .power_down_req(power_down_req),
        .capture_ready(capture_ready), .core_ready(core_ready),
        .drive(drive), .drive_valid(drive_valid));

    // A twos complement word is offset by half scale to reach the unsigned code.
    function automatic dacil_code_t exp_code(input dacil_code_t v, input logic fmt);
        exp_code = (fmt === `DACIL_FMT_TWOS) ? dacil_code_t'(int'($signed(v)) + 512) : v;
    endfunction : exp_code

    task automatic flag(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: %s is %b", $time, what, got);
        end
    endtask : flag

    // Primary follows the code, complementary carries the rest of full scale.
    task automatic check_drive(input dacil_code_t code);
        n_compared++;
        if (drive.primary !== code || drive.complementary !== (`DACIL_CODE_FULL - code)
            || drive.powered_down !== 1'b0)
        begin
            bad_count++;
            $display("ERROR %0t: drive %h/%h for code %h", $time, drive.primary,
                     drive.complementary, code);
        end
    endtask : check_drive

    // Hold a word long enough to pass the synchronisers and the buffer.
    task automatic apply(input dacil_code_t v, input logic fmt);
        @(posedge mclk);
        word_in <= v;
        @(negedge mclk);
        format_select = fmt;
        repeat (8) @(negedge mclk);
        check_drive(exp_code(v, fmt));
    endtask : apply

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Cut a hang short; the whole run needs well under a thousand cycles.
    initial
    begin
        #(40 * 5000);
        bad_count++;
        results();
    end

    initial
    begin
        void'($urandom(77021));
        repeat (5) @(negedge mclk);
        flag(drive.powered_down, 1'b1, "reset powered_down");
        flag(drive_valid, 1'b0, "reset drive_valid");
        flag(capture_ready, 1'b1, "reset capture_ready");
        repeat (5) @(negedge mclk);
        rst_b = 1'b1;
        // Bit order and both end codes, in both formats.
        apply(10'h200, `DACIL_FMT_BINARY);
        apply(10'h001, `DACIL_FMT_BINARY);
        apply(`DACIL_CODE_FULL, `DACIL_FMT_BINARY);
        apply(`DACIL_CODE_ZERO, `DACIL_FMT_BINARY);
        apply(10'h1ff, `DACIL_FMT_TWOS);
        apply(10'h200, `DACIL_FMT_TWOS);
        flag(drive_valid, 1'b1, "drive_valid");
        for (int i = 0; i < 20; i++)
            apply(dacil_code_t'($urandom), 1'($urandom));
        // Back-to-back words, one per edge, reach the drive four falling edges later.
        format_select = `DACIL_FMT_BINARY;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 200; i++)
        begin
            w = dacil_code_t'($urandom);
            @(posedge mclk);
            word_in <= w;
            @(negedge mclk);
            hist.push_back(w);
            if (hist.size() > 4)
                check_drive(hist.pop_front());
        end
        // Stall the core until the buffer refuses, then release the core so capture_ready returns.
        core_ready = 1'b0;
        repeat (24) @(negedge mclk);
        flag(capture_ready, 1'b0, "capture_ready while full");
        core_ready = 1'b1;
        repeat (40) @(negedge mclk);
        flag(capture_ready, 1'b1, "capture_ready after drain");
        check_drive(w);
        // Power-down and return.
        power_down_req = 1'b1;
        repeat (8) @(negedge mclk);
        flag(drive.powered_down, 1'b1, "powered_down in sleep");
        flag(drive_valid, 1'b0, "drive_valid in sleep");
        power_down_req = 1'b0;
        repeat (10) @(negedge mclk);
        check_drive(w);
        flag(drive_valid, 1'b1, "drive_valid after wake");
        results();
    end
endmodule : dac_input_latch_format_bench
